// [design/bcs_pkg.sv]
// Constants, types and helper functions of the branch and status decoder.
package bcs_pkg;
  localparam int ADDR_W      = 15;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  // Operation classes held in opcode bits 7 to 2.
  localparam logic [5:0] OP_CMP_REG = 6'h38;
  localparam logic [5:0] OP_CMP_IMM = 6'h39;
  localparam logic [5:0] OP_CMP_REL = 6'h3A;
  localparam logic [5:0] OP_CMP_ABS = 6'h3B;
  localparam logic [5:0] OP_ROT_R   = 6'h14;
  localparam logic [5:0] OP_ROT_L   = 6'h34;
  localparam logic [5:0] OP_JT_R    = 6'h06;
  localparam logic [5:0] OP_JT_A    = 6'h07;
  localparam logic [5:0] OP_JF_R    = 6'h26;
  localparam logic [5:0] OP_JF_A    = 6'h27;
  localparam logic [5:0] OP_JNZ_R   = 6'h16;
  localparam logic [5:0] OP_JNZ_A   = 6'h17;
  localparam logic [5:0] OP_JINC_R  = 6'h36;
  localparam logic [5:0] OP_JINC_A  = 6'h37;
  localparam logic [5:0] OP_JDEC_R  = 6'h3E;
  localparam logic [5:0] OP_JDEC_A  = 6'h3F;
  localparam logic [5:0] OP_CT_R    = 6'h0E;
  localparam logic [5:0] OP_CT_A    = 6'h0F;
  localparam logic [5:0] OP_CF_R    = 6'h2E;
  localparam logic [5:0] OP_CF_A    = 6'h2F;
  localparam logic [5:0] OP_CNZ_R   = 6'h1E;
  localparam logic [5:0] OP_CNZ_A   = 6'h1F;
  localparam logic [5:0] OP_RET     = 6'h05;
  localparam logic [5:0] OP_RETE    = 6'h0D;
  localparam logic [5:0] OP_TMI     = 6'h3D;
  // Whole opcode bytes.
  localparam logic [7:0] B_HALT      = 8'h40;
  localparam logic [7:0] B_NOP       = 8'hC0;
  localparam logic [7:0] B_LPSU      = 8'h92;
  localparam logic [7:0] B_LPSL      = 8'h93;
  localparam logic [7:0] B_SPSU      = 8'h12;
  localparam logic [7:0] B_SPSL      = 8'h13;
  localparam logic [7:0] B_CPSU      = 8'h74;
  localparam logic [7:0] B_CPSL      = 8'h75;
  localparam logic [7:0] B_PPSU      = 8'h76;
  localparam logic [7:0] B_PPSL      = 8'h77;
  localparam logic [7:0] B_TPSU      = 8'hB4;
  localparam logic [7:0] B_TPSL      = 8'hB5;
  localparam logic [7:0] B_JUMP_IDX  = 8'h9F;
  localparam logic [7:0] B_CALL_IDX  = 8'hBF;
  // Condition code values and the always-true condition field.
  localparam logic [1:0] CC_POS   = 2'h1;
  localparam logic [1:0] CC_ZERO  = 2'h0;
  localparam logic [1:0] CC_NEG   = 2'h2;
  localparam logic [1:0] COND_ANY = 2'h3;
  // Bit positions in the lower and upper status bytes.
  localparam int LO_CC_LSB = 6;
  localparam int LO_IDC    = 5;
  localparam int LO_BANK   = 4;
  localparam int LO_WC     = 3;
  localparam int LO_OVF    = 2;
  localparam int LO_COM    = 1;
  localparam int LO_C      = 0;
  localparam int UP_FLAG   = 6;
  localparam int UP_II     = 5;
  localparam logic [7:0] UP_WRITABLE = 8'h67;
  localparam logic [7:0] LO_RESET    = 8'h00;
  // Instruction lengths in processor cycles.
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_exec = 3'b010,
    st_wait = 3'b100
  } state_t;

  // Condition code of a value seen as a signed byte.
  function automatic logic [1:0] cc_of_value(input logic [7:0] v);
    if (v == 8'h00) return CC_ZERO;
    return v[7] ? CC_NEG : CC_POS;
  endfunction

  // Condition code of a compare, unsigned when logical is set.
  function automatic logic [1:0] cc_compare(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic       logical);
    logic gt;
    gt = logical ? (a > b) : ($signed(a) > $signed(b));
    if (a == b) return CC_ZERO;
    return gt ? CC_POS : CC_NEG;
  endfunction

  // Condition code of a test under mask.
  function automatic logic [1:0] cc_mask(input logic [7:0] v,
                                         input logic [7:0] m);
    return ((v & m) == m) ? CC_ZERO : CC_NEG;
  endfunction
endpackage

// [design/psw_if.sv]
// Status word access channel between the decoder and the status registers.
interface psw_if;
  import bcs_pkg::*;
  logic [7:0]        upper;
  logic [7:0]        lower;
  logic              wr_upper;
  logic [7:0]        upper_wdata;
  logic              wr_lower;
  logic [7:0]        lower_wdata;
  logic              push;
  logic              pop;
  logic              clear_ii;
  logic [ADDR_W-1:0] push_addr;
  logic [ADDR_W-1:0] top_addr;
  modport decoder (input upper, lower, top_addr, output wr_upper,
                   upper_wdata, wr_lower, lower_wdata, push, pop,
                   clear_ii, push_addr);
  modport store (output upper, lower, top_addr, input wr_upper,
                 upper_wdata, wr_lower, lower_wdata, push, pop,
                 clear_ii, push_addr);
endinterface

// [design/psw_regs.sv]
// Program status bytes and the return address stack.
module psw_regs (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic sense_in,
  psw_if.store      psw
);
  import bcs_pkg::*;
  logic [ADDR_W-1:0] stack [STACK_DEPTH];
  logic [SP_W-1:0]   sp;
  logic              flag;
  logic              inhibit;
  logic              sense;
  logic [7:0]        lower;

  // Upper byte reads sense, flag, inhibit, two zero bits and the pointer.
  assign psw.upper    = {sense, flag, inhibit, 2'b00, sp}; // [RULE27] [RULE29]
  assign psw.lower    = lower; // [RULE26]
  assign psw.top_addr = stack[sp];

  // The sense pin is registered so the status byte comes from a flop.
  always_ff @(posedge ref_clk) begin
    sense <= rst ? 1'b0 : sense_in;
  end

  // Flag and interrupt inhibit; writes to the unused bits are dropped.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag    <= 1'b0;
      inhibit <= 1'b0;
    end else if (psw.wr_upper) begin
      flag    <= psw.upper_wdata[UP_FLAG]; // [RULE29]
      inhibit <= psw.upper_wdata[UP_II];
    end else if (psw.clear_ii) begin
      inhibit <= 1'b0; // [RULE15]
    end
  end

  // Stack pointer moves up on a push and down on a pop.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sp <= '0;
    end else if (psw.wr_upper) begin
      sp <= psw.upper_wdata[SP_W-1:0];
    end else if (psw.push) begin
      sp <= sp + SP_W'(1); // [RULE25]
    end else if (psw.pop) begin
      sp <= sp - SP_W'(1); // [RULE25]
    end
  end

  // A push stores the return address in the next slot.
  always_ff @(posedge ref_clk) begin
    if (psw.push) begin
      stack[sp + SP_W'(1)] <= psw.push_addr; // [RULE25]
    end
  end

  // Lower status byte.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lower <= LO_RESET;
    end else if (psw.wr_lower) begin
      lower <= psw.lower_wdata; // [RULE26]
    end
  end
endmodule

// [design/rotate_unit.sv]
// One-place register rotate with optional carry linkage.
module rotate_unit (
  input  wire logic [7:0] value,
  input  wire logic       carry_in,
  input  wire logic       idc_in,
  input  wire logic       with_carry,
  input  wire logic       left,
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            idc_out,
  output logic            ovf_out
);
  // Through carry the carry bit joins the ring, else the byte closes on itself.
  always_comb begin
    if (left) begin
      result    = {value[6:0], with_carry ? carry_in : value[7]}; // [RULE4]
      carry_out = with_carry ? value[7] : carry_in;
    end else begin
      result    = {with_carry ? carry_in : value[0], value[7:1]}; // [RULE4]
      carry_out = with_carry ? value[0] : carry_in;
    end
    idc_out = with_carry ? result[5] : idc_in;
    ovf_out = result[7] ^ value[7];
  end
endmodule

// [design/branch_status_decoder.sv]
// Decoder and executor for compare, rotate, branch, call and status operations.
// Operation
// [RULE1] Compare family decode, two to four cycles
// [RULE2] Register-zero compare sets condition code
// [RULE3] Fetched-value compare sets condition code
// [RULE4] Rotate right and left with flags
// [RULE5] Jump if condition true, flags kept
// [RULE6] Jump if condition false, flags kept
// [RULE7] Jump if register nonzero, flags kept
// [RULE8] Increment register then jump if nonzero
// [RULE9] Decrement register then jump if nonzero
// [RULE10] Page-zero and indexed unconditional jumps
// [RULE11] Index is always register three
// [RULE12] Conditional calls push return address
// [RULE13] Call if register nonzero
// [RULE14] Page-zero and indexed unconditional calls
// [RULE15] Conditional return, one variant enables interrupts
// [RULE16] Read and status store set condition code; a read that arrives in the final cycle of an instruction is dropped
// [RULE17] Halt enters wait, no-operation does nothing
// [RULE18] Immediate mask test of a register
// [RULE19] Mask tests give zero or negative
// [RULE20] Status load, upper and lower bytes
// [RULE21] Status save copies byte, sets code
// [RULE22] Masked clear of status bits
// [RULE23] Masked set of status bits
// [RULE24] Masked test of status bits
// [RULE25] Eight-deep return stack indexed by pointer
// [RULE26] Lower status byte field layout
// [RULE27] Upper status byte field layout
// [RULE28] Updated register written before nonzero test
// [RULE29] Upper unused bits read zero
module branch_status_decoder (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        instr_valid,
  input  wire logic [7:0]                  opcode,
  input  wire logic [7:0]                  operand,
  input  wire logic [bcs_pkg::ADDR_W-1:0]  target_addr,
  input  wire logic [bcs_pkg::ADDR_W-1:0]  return_addr,
  input  wire logic [7:0]                  reg_rdata,
  input  wire logic [7:0]                  r0_data,
  input  wire logic                        io_read_valid,
  input  wire logic [7:0]                  io_read_data,
  input  wire logic                        sense_in,
  input  wire logic                        wake,
  output logic      [1:0]                  reg_sel,
  output logic                             reg_bank,
  output logic                             claimed,
  output logic                             busy,
  output logic                             done,
  output logic                             halted,
  output logic                             reg_we,
  output logic      [1:0]                  reg_wsel,
  output logic      [7:0]                  reg_wdata,
  output logic                             pc_load,
  output logic      [bcs_pkg::ADDR_W-1:0]  pc_target,
  output logic      [7:0]                  status_upper,
  output logic      [7:0]                  status_lower
);
  import bcs_pkg::*;

  psw_if psw ();

  state_t            state;
  logic [2:0]        cnt;
  logic [7:0]        lat_op;
  logic [7:0]        lat_v;
  logic [7:0]        lat_r;
  logic [7:0]        lat_r0;
  logic [ADDR_W-1:0] lat_tgt;
  logic [ADDR_W-1:0] lat_ret;
  logic              take;
  logic              commit;
  logic [5:0]        op6;
  logic [1:0]        cond;
  logic [1:0]        cc;
  logic              cond_true;
  logic [7:0]        inc_val;
  logic [7:0]        dec_val;
  logic [ADDR_W-1:0] idx_target;
  logic [SP_W-1:0]   sp_now;
  logic              is_branch;
  logic [7:0]        rot_res;
  logic              rot_c;
  logic              rot_idc;
  logic              rot_ovf;
  logic              jump;
  logic              call;
  logic              index;
  logic              ret_pop;
  logic              next_halt;
  logic              next_reg_we;
  logic [1:0]        next_reg_wsel;
  logic [7:0]        next_reg_wdata;

  // Length of a recognised opcode in cycles, zero for any other byte.
  function automatic logic [2:0] cycles_of(input logic [7:0] b);
    logic [2:0] n;
    n = 3'h0;
    case (b[7:2])
      OP_CMP_REG, OP_CMP_IMM, OP_ROT_R, OP_ROT_L: n = CYC_TWO; // [RULE1]
      OP_CMP_REL, OP_JT_R, OP_JT_A, OP_JF_R, OP_JF_A, OP_JNZ_R, OP_JNZ_A,
      OP_JINC_R, OP_JINC_A, OP_JDEC_R, OP_JDEC_A, OP_CT_R, OP_CT_A,
      OP_CF_R, OP_CF_A, OP_CNZ_R, OP_CNZ_A, OP_RET, OP_RETE,
      OP_TMI: n = CYC_THREE; // [RULE1] [RULE5] [RULE12] [RULE15]
      OP_CMP_ABS: n = CYC_FOUR; // [RULE1]
      default: n = 3'h0;
    endcase
    case (b)
      B_HALT, B_NOP, B_LPSU, B_LPSL, B_SPSU, B_SPSL: n = CYC_TWO; // [RULE17]
      B_CPSU, B_CPSL, B_PPSU, B_PPSL, B_TPSU, B_TPSL: n = CYC_THREE;
      default: n = n;
    endcase
    return n;
  endfunction

  psw_regs u_psw (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .sense_in (sense_in),
    .psw      (psw.store)
  );

  rotate_unit u_rot (
    .value      (lat_r),
    .carry_in   (psw.lower[LO_C]),
    .idc_in     (psw.lower[LO_IDC]),
    .with_carry (psw.lower[LO_WC]),
    .left       (lat_op[7]),
    .result     (rot_res),
    .carry_out  (rot_c),
    .idc_out    (rot_idc),
    .ovf_out    (rot_ovf)
  );

  // Handshake and decode terms.
  assign reg_sel      = opcode[1:0]; // [RULE11]
  assign claimed      = instr_valid && (cycles_of(opcode) != 3'h0);
  assign take         = claimed && (state == st_idle);
  assign commit       = (state == st_exec) && (cnt == 3'h1);
  assign busy         = (state != st_idle);
  assign halted       = (state == st_wait);
  assign op6          = lat_op[7:2];
  assign cond         = lat_op[1:0];
  assign cc           = psw.lower[LO_CC_LSB +: 2];
  assign cond_true    = (cond == COND_ANY) || (cc == cond);
  assign inc_val      = lat_r + 8'h01;
  assign dec_val      = lat_r - 8'h01;
  assign idx_target   = lat_tgt + ADDR_W'(lat_r); // [RULE11]
  assign sp_now       = psw.upper[SP_W-1:0];
  assign reg_bank     = psw.lower[LO_BANK];
  assign status_upper = psw.upper;
  assign status_lower = psw.lower;
  assign is_branch    = (op6[2:1] == 2'b11) && (lat_op[7:2] != OP_CMP_ABS) &&
                        (lat_op[7:2] != OP_CMP_REL);

  // Sequencer: idle, executing for the opcode's length, or halted.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: if (take) state <= st_exec;
        st_exec: if (commit) state <= next_halt ? st_wait : st_idle; // [RULE17]
        st_wait: if (wake) state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // Cycle counter of the running instruction.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 3'h0;
    end else if (take) begin
      cnt <= cycles_of(opcode) - 3'h1; // [RULE1]
    end else if ((state == st_exec) && !commit) begin
      cnt <= cnt - 3'h1;
    end
  end

  // Opcode, operand and register values are held for the whole instruction.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lat_op  <= B_NOP;
      lat_v   <= 8'h00;
      lat_r   <= 8'h00;
      lat_r0  <= 8'h00;
      lat_tgt <= '0;
      lat_ret <= '0;
    end else if (take) begin
      lat_op  <= opcode;
      lat_v   <= operand;
      lat_r   <= reg_rdata;
      lat_r0  <= r0_data;
      lat_tgt <= target_addr;
      lat_ret <= return_addr;
    end
  end

  // Effects of the final cycle of each instruction.
  always_comb begin
    next_reg_we     = 1'b0;
    next_reg_wsel   = lat_op[1:0];
    next_reg_wdata  = lat_r;
    jump            = 1'b0;
    call            = 1'b0;
    index           = 1'b0;
    ret_pop         = 1'b0;
    next_halt       = 1'b0;
    psw.wr_upper    = 1'b0;
    psw.upper_wdata = psw.upper & UP_WRITABLE;
    psw.wr_lower    = 1'b0;
    psw.lower_wdata = psw.lower;
    psw.clear_ii    = 1'b0;
    if (commit) begin
      case (lat_op)
        B_HALT: next_halt = 1'b1; // [RULE17]
        B_NOP: next_halt = 1'b0; // [RULE17]
        B_LPSU: begin
          psw.wr_upper    = 1'b1;
          psw.upper_wdata = lat_r0 & UP_WRITABLE; // [RULE20]
        end
        B_LPSL: begin
          psw.wr_lower    = 1'b1;
          psw.lower_wdata = lat_r0; // [RULE20]
        end
        B_SPSU, B_SPSL: begin
          next_reg_we    = 1'b1;
          next_reg_wsel  = 2'h0;
          next_reg_wdata = lat_op[0] ? psw.lower : psw.upper; // [RULE21]
          psw.wr_lower   = 1'b1;
          psw.lower_wdata[LO_CC_LSB +: 2] =
            cc_of_value(next_reg_wdata); // [RULE16] [RULE21]
        end
        B_CPSU: begin
          psw.wr_upper    = 1'b1;
          psw.upper_wdata = psw.upper & ~lat_v & UP_WRITABLE; // [RULE22]
        end
        B_CPSL: begin
          psw.wr_lower    = 1'b1;
          psw.lower_wdata = psw.lower & ~lat_v; // [RULE22]
        end
        B_PPSU: begin
          psw.wr_upper    = 1'b1;
          psw.upper_wdata = (psw.upper | lat_v) & UP_WRITABLE; // [RULE23]
        end
        B_PPSL: begin
          psw.wr_lower    = 1'b1;
          psw.lower_wdata = psw.lower | lat_v; // [RULE23]
        end
        B_TPSU, B_TPSL: begin
          psw.wr_lower = 1'b1;
          psw.lower_wdata[LO_CC_LSB +: 2] = cc_mask(
            lat_op[0] ? psw.lower : psw.upper, lat_v); // [RULE24] [RULE19]
        end
        default: begin
          case (op6)
            OP_CMP_REG: begin
              psw.wr_lower = 1'b1;
              psw.lower_wdata[LO_CC_LSB +: 2] =
                cc_compare(lat_r0, lat_r, psw.lower[LO_COM]); // [RULE2]
            end
            OP_CMP_IMM, OP_CMP_REL, OP_CMP_ABS: begin
              psw.wr_lower = 1'b1;
              psw.lower_wdata[LO_CC_LSB +: 2] =
                cc_compare(lat_r, lat_v, psw.lower[LO_COM]); // [RULE3]
            end
            OP_ROT_R, OP_ROT_L: begin
              next_reg_we                     = 1'b1;
              next_reg_wdata                  = rot_res; // [RULE4]
              psw.wr_lower                    = 1'b1;
              psw.lower_wdata[LO_C]           = rot_c;
              psw.lower_wdata[LO_IDC]         = rot_idc;
              psw.lower_wdata[LO_OVF]         = rot_ovf;
              psw.lower_wdata[LO_CC_LSB +: 2] = cc_of_value(rot_res);
            end
            OP_JT_R, OP_JT_A: jump = cond_true; // [RULE5]
            OP_JF_R, OP_JF_A: begin
              jump  = (cond == COND_ANY) || (cc != cond); // [RULE6] [RULE10]
              index = (lat_op == B_JUMP_IDX); // [RULE10] [RULE11]
            end
            OP_JNZ_R, OP_JNZ_A: jump = (lat_r != 8'h00); // [RULE7]
            OP_JINC_R, OP_JINC_A: begin
              next_reg_we    = 1'b1;
              next_reg_wdata = inc_val; // [RULE8] [RULE28]
              jump           = (inc_val != 8'h00); // [RULE28]
            end
            OP_JDEC_R, OP_JDEC_A: begin
              next_reg_we    = 1'b1;
              next_reg_wdata = dec_val; // [RULE9] [RULE28]
              jump           = (dec_val != 8'h00); // [RULE28]
            end
            OP_CT_R, OP_CT_A: call = cond_true; // [RULE12]
            OP_CF_R, OP_CF_A: begin
              call  = (cond == COND_ANY) || (cc != cond); // [RULE12] [RULE14]
              index = (lat_op == B_CALL_IDX); // [RULE14] [RULE11]
            end
            OP_CNZ_R, OP_CNZ_A: call = (lat_r != 8'h00); // [RULE13]
            OP_RET, OP_RETE: begin
              ret_pop      = cond_true; // [RULE15]
              psw.clear_ii = cond_true && lat_op[5]; // [RULE15]
            end
            OP_TMI: begin
              psw.wr_lower = 1'b1;
              psw.lower_wdata[LO_CC_LSB +: 2] =
                cc_mask(lat_r, lat_v); // [RULE18] [RULE19]
            end
            default: jump = 1'b0;
          endcase
        end
      endcase
    end else if (io_read_valid) begin
      psw.wr_lower = 1'b1;
      psw.lower_wdata[LO_CC_LSB +: 2] = cc_of_value(io_read_data); // [RULE16]
    end
  end

  // Stack traffic for calls and returns.
  assign psw.push      = call; // [RULE12] [RULE14]
  assign psw.pop       = ret_pop; // [RULE15]
  assign psw.push_addr = lat_ret;

  // Registered answers to the register file and the fetch sequencer.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done      <= 1'b0;
      reg_we    <= 1'b0;
      reg_wsel  <= 2'h0;
      reg_wdata <= 8'h00;
      pc_load   <= 1'b0;
      pc_target <= '0;
    end else begin
      done      <= commit;
      reg_we    <= next_reg_we;
      reg_wsel  <= next_reg_wsel;
      reg_wdata <= next_reg_wdata;
      pc_load   <= jump || call || ret_pop;
      pc_target <= ret_pop ? psw.top_addr :
                   (index ? idx_target : lat_tgt);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_take_cmp_abs;
    take && (opcode[7:2] == OP_CMP_ABS);
  endsequence
  sequence s_take_halt;
    take && (opcode == B_HALT);
  endsequence

  a_cmp_abs_len: // [RULE1]
    assert property (s_take_cmp_abs |=> !done [*3] ##1 done)
    else $error("absolute compare did not take four cycles");
  a_cmp_zero_eq: // [RULE2]
    assert property (commit && (op6 == OP_CMP_REG) && (lat_r0 == lat_r)
                     |=> status_lower[LO_CC_LSB +: 2] == CC_ZERO)
    else $error("equal register compare gave wrong code");
  a_cmp_val_less: // [RULE3]
    assert property (commit && (op6 == OP_CMP_IMM) && status_lower[LO_COM]
                     && (lat_r < lat_v)
                     |=> status_lower[LO_CC_LSB +: 2] == CC_NEG)
    else $error("smaller register compare gave wrong code");
  a_branch_flags: // [RULE5]
    assert property (commit && is_branch |=> $stable(status_lower))
    else $error("branch changed the lower status byte");
  a_index_jump: // [RULE10]
    assert property (commit && (lat_op == B_JUMP_IDX)
                     |=> pc_load && (pc_target == $past(idx_target)))
    else $error("indexed jump went to the wrong address");
  a_call_push: // [RULE12]
    assert property (commit && call |=> sp_now == $past(sp_now) + 3'h1)
    else $error("call did not advance the stack pointer");
  a_halt_wait: // [RULE17]
    assert property (s_take_halt |=> !halted ##1 halted)
    else $error("halt did not enter the wait state in two cycles");
  a_mask_allset: // [RULE19]
    assert property (commit && (op6 == OP_TMI) && ((lat_r & lat_v) == lat_v)
                     |=> status_lower[LO_CC_LSB +: 2] == CC_ZERO)
    else $error("mask test with all bits set gave wrong code");
  a_upper_unused: // [RULE29]
    assert property (status_upper[4:3] == 2'b00)
    else $error("unused upper status bits are not zero");
endmodule

// [testbench/reg_file_model.sv]
// Register file model that answers the decoder's register reads and writes.
module reg_file_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] reg_sel,
  input  wire logic       reg_we,
  input  wire logic [1:0] reg_wsel,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] r0_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4];
  // Reads are immediate, so the selected register is always presented.
  assign reg_rdata = mem[reg_sel];
  assign r0_data   = mem[0];
  // Write-back lands on the edge that carries the write strobe.
  always @(posedge ref_clk) if (reg_we) mem[reg_wsel] <= reg_wdata;
endmodule

// [testbench/tb_branch_status_decoder.sv]
// Self-checking bench of the branch and status decoder.
module tb_branch_status_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  import bcs_pkg::*;
  logic        ref_clk = 0, rst = 1, instr_valid = 0, sense_in = 0;
  logic        wake = 0, io_read_valid = 0;
  logic [7:0]  opcode = 0, operand = 0, io_read_data = 0;
  logic [14:0] target_addr = 15'h1234, return_addr = 15'h0456, pc_target;
  logic [7:0]  reg_rdata, r0_data, reg_wdata, status_upper, status_lower;
  logic [1:0]  reg_sel, reg_wsel;
  logic        reg_bank, claimed, busy, done, halted, reg_we, pc_load;
  int          n_mismatch = 0, n_checks = 0;
  branch_status_decoder dut (.ref_clk, .rst, .instr_valid, .opcode,
    .operand, .target_addr, .return_addr, .reg_rdata, .r0_data,
    .io_read_valid, .io_read_data, .sense_in, .wake, .reg_sel, .reg_bank,
    .claimed, .busy, .done, .halted, .reg_we, .reg_wsel, .reg_wdata,
    .pc_load, .pc_target, .status_upper, .status_lower);
  reg_file_model regs (.ref_clk, .reg_sel, .reg_we, .reg_wsel, .reg_wdata,
    .reg_rdata, .r0_data);
  // Clock of 20 ns period.
  always #10 ref_clk = ~ref_clk;
  // Counts a comparison and reports a mismatch.
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  // Issues one instruction and checks its length in cycles.
  task automatic exec(input logic [7:0] op, input logic [7:0] od,
                      input int n);
    int c;
    @(negedge ref_clk);
    instr_valid = 1;
    opcode = op;
    operand = od;
    @(negedge ref_clk);
    instr_valid = 0;
    c = 0;
    while (done !== 1'b1 && c < 8) begin
      @(negedge ref_clk);
      c++;
    end
    chk(c == n - 1, "instruction length");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    #20000;
    n_mismatch++;
    finish_test();
  end
  // Main test sequence.
  initial begin
    regs.mem[0] = 8'hFF;
    regs.mem[1] = 8'h80;
    regs.mem[2] = 8'h01;
    regs.mem[3] = 8'h10;
    repeat (5) @(negedge ref_clk);
    rst = 0;
    instr_valid = 1;
    chk(status_upper === 8'h00 && status_lower === 8'h00, "reset");
    @(negedge ref_clk);
    chk(claimed === 1'b0 && busy === 1'b0, "refused opcode");
    instr_valid = 0;
    exec(B_PPSL, 8'h02, 3);
    chk(status_lower === 8'h02, "preset lower");
    exec({OP_CMP_IMM, 2'h1}, 8'h90, 2);
    chk(status_lower[7:6] === CC_NEG, "logical less");
    exec({OP_CMP_REG, 2'h0}, 8'h00, 2);
    chk(status_lower[7:6] === CC_ZERO, "register compare");
    exec({OP_CMP_IMM, 2'h1}, 8'h7F, 2);
    chk(status_lower[7:6] === CC_POS, "logical compare");
    exec(B_CPSL, 8'h02, 3);
    exec({OP_CMP_IMM, 2'h1}, 8'h7F, 2);
    chk(status_lower[7:6] === CC_NEG, "signed compare");
    exec({OP_CMP_ABS, 2'h1}, 8'h80, 4);
    chk(status_lower[7:6] === CC_ZERO, "equal compare");
    exec({OP_TMI, 2'h1}, 8'h81, 3);
    chk(status_lower[7:6] === CC_NEG, "mask miss");
    exec({OP_TMI, 2'h1}, 8'h80, 3);
    chk(status_lower[7:6] === CC_ZERO, "mask test");
    $display("compare and mask tests done");
    exec({OP_CT_A, COND_ANY}, 8'h00, 3);
    chk(pc_load === 1'b1 && pc_target === 15'h1234, "call");
    chk(status_upper[2:0] === 3'h1, "push pointer");
    target_addr = 15'h0000;
    exec({OP_RET, COND_ANY}, 8'h00, 3);
    chk(pc_target === 15'h0456, "return address");
    chk(status_upper[2:0] === 3'h0, "pop pointer");
    exec({OP_JDEC_R, 2'h2}, 8'h00, 3);
    chk(reg_we === 1'b1 && reg_wdata === 8'h00, "dec write");
    chk(reg_wsel === 2'h2, "dec target");
    chk(pc_load === 1'b0, "no jump");
    chk(status_lower[7:6] === CC_ZERO, "flags kept");
    exec({OP_ROT_L, 2'h1}, 8'h00, 2);
    chk(reg_wdata === 8'h01 && status_lower === 8'h44, "rotate");
    $display("call and branch tests done");
    exec(B_HALT, 8'h00, 2);
    chk(halted === 1'b1, "halt");
    wake = 1;
    @(negedge ref_clk);
    wake = 0;
    chk(halted === 1'b0, "wake");
    io_read_valid = 1;
    io_read_data = 8'hF0;
    @(negedge ref_clk);
    io_read_valid = 0;
    chk(status_lower[7:6] === CC_NEG, "read code");
    exec(B_LPSU, 8'hFF, 2);
    chk(status_upper === 8'h67, "load upper");
    exec({OP_RETE, COND_ANY}, 8'h00, 3);
    chk(status_upper === 8'h46, "return enable");
    exec(B_JUMP_IDX, 8'h00, 3);
    chk(pc_load === 1'b1 && pc_target === 15'h0010, "indexed jump");
    $display("halt and status tests done");
    finish_test();
  end
endmodule
